// ==== hdl/lmc_pkg.sv ====
// Package with register map, field layout and state types of the misc block.
package lmc_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0]  OFS_LINK_CTRL = 8'h44;
    localparam logic [7:0]  OFS_LINK_FREQ = 8'h48;
    localparam logic [7:0]  OFS_MISC      = 8'h50;
    localparam int          ADDR_W        = 8;

    // ------------------------------------------------------------------
    // Field positions of misc_link_control
    // ------------------------------------------------------------------
    localparam int BIT_RSVD     = 31;
    localparam int BIT_STOP     = 30;
    localparam int BIT_WAKE     = 29;
    localparam int RDR_HI       = 28;
    localparam int RDR_LO       = 24;
    localparam int BIT_DWORD    = 23;
    localparam int BIT_COHER    = 22;
    localparam int BIT_IGN_ORD  = 21;
    localparam int BIT_KEEP_ID  = 20;
    localparam int SEQ_HI       = 19;
    localparam int SEQ_LO       = 16;
    localparam int PRIO_NOP_LO  = 12;
    localparam int PRIO_NPC_LO  = 8;
    localparam int PRIO_RSP_LO  = 4;
    localparam int PRIO_PST_LO  = 0;
    localparam int PRIO_W       = 4;

    // Field positions in the link control and frequency registers.
    localparam int BIT_TRI_EN   = 13;
    localparam int FREQ_HI      = 11;
    localparam int FREQ_LO      = 8;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] MISC_RESET  = 32'h0090_4321;
    localparam logic [31:0] CTRL_RESET  = 32'h0000_2000;
    localparam logic [3:0]  FREQ_RESET  = 4'h0;
    localparam logic [3:0]  PRIO_MAX    = 4'hF;
    localparam logic [3:0]  PRIO_TOP    = 4'h0;

    // Special interrupt type codes in the low vector bits.
    localparam logic [2:0]  IRQ_SMI     = 3'h0;
    localparam logic [2:0]  IRQ_NMI     = 3'h1;
    localparam logic [2:0]  IRQ_INIT    = 3'h2;
    localparam logic [2:0]  IRQ_RSVD    = 3'h3;
    localparam int          NUM_CH      = 4;

    // Link power states.
    typedef enum logic [1:0] {
        LINK_UP,
        LINK_DISC,
        LINK_WAKE
    } lmc_state_t;

endpackage

// ==== hdl/lmc_arbiter.sv ====
// Aging arbiter for the four link channels.
`timescale 1ns/1ps
module lmc_arbiter
    import lmc_pkg::*;
(
    // Clock and reset
    input  wire logic                       ref_clk,
    input  wire logic                       reset,
    // Initial priorities, index 0 nop, 1 npc, 2 rsp, 3 posted
    input  wire logic [NUM_CH*PRIO_W-1:0]   init_prio,
    // Requests and registered one-hot grants
    input  wire logic [NUM_CH-1:0]          ch_req,
    output logic      [NUM_CH-1:0]          ch_grant
);

    logic [PRIO_W-1:0] age_reg [NUM_CH];
    logic [PRIO_W-1:0] eff     [NUM_CH];
    logic [NUM_CH-1:0] win;

    // Effective priority is the initial one lowered by waiting time.
    function automatic logic [PRIO_W-1:0] boost(input logic [PRIO_W-1:0] p,
                                                input logic [PRIO_W-1:0] a);
        boost = (p > a) ? p - a : PRIO_TOP;
    endfunction

    // Pick the smallest effective value; ties go to the lower index.
    always_comb begin
        logic [PRIO_W-1:0] best;
        logic              found;
        best  = PRIO_MAX;
        found = 1'b0;
        win   = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            eff[i] = boost(init_prio[i*PRIO_W +: PRIO_W], age_reg[i]);
        end
        for (int i = 0; i < NUM_CH; i++) begin
            if (ch_req[i] && (!found || eff[i] < best)) begin
                best  = eff[i];
                found = 1'b1;
                win   = '0;
                win[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < NUM_CH; i++) begin
                age_reg[i] <= PRIO_TOP;
            end
            ch_grant <= '0;
        end else begin
            ch_grant <= win;
            for (int i = 0; i < NUM_CH; i++) begin
                if (win[i] || !ch_req[i]) begin
                    age_reg[i] <= PRIO_TOP;
                end else if (age_reg[i] != PRIO_MAX) begin
                    age_reg[i] <= age_reg[i] + 4'h1;
                end
            end
        end
    end

    // grant goes only to a requester
    a_grant_req_onehot: assert property (
        @(posedge ref_clk) disable iff (reset)
        |ch_grant |-> $onehot(ch_grant) && |(ch_grant & $past(ch_req)))
        else $error("grant without request or not one-hot");

endmodule

// ==== hdl/lmc_top.sv ====
// Misc link control register bank with stop, wake and channel control.
`timescale 1ns/1ps
module lmc_top
    import lmc_pkg::*;
(
    // Clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   reset,
    // Wishbone classic slave
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [ADDR_W-1:0]      wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic      [31:0]            wb_dat_o,
    output logic                        wb_ack_o,
    // Link power pins
    output logic                        link_halt_signal_n,
    output logic                        link_req_n,
    output logic                        phy_shutdown,
    output logic      [3:0]             active_link_freq,
    input  wire logic                   link_access_req,
    // Strap
    input  wire logic                   coherency_strap_pin,
    // Special interrupt vector
    input  wire logic                   special_irq_valid,
    input  wire logic [2:0]             special_irq_type,
    output logic                        irq_vector_valid,
    output logic      [7:0]             irq_vector,
    // Command formatting
    input  wire logic [3:0]             axi_seq_id,
    output logic      [3:0]             cmd_seq_id,
    output logic                        wide_write_dword,
    output logic                        ignore_ordering,
    // Channel arbitration
    input  wire logic [NUM_CH-1:0]      ch_req,
    output logic      [NUM_CH-1:0]      ch_grant
);

    // ------------------------------------------------------------------
    // Registers and decode
    // ------------------------------------------------------------------
    logic [31:0]  misc_reg;
    logic [31:0]  misc_next;
    logic [31:0]  ctrl_reg;
    logic [3:0]   freq_reg;
    logic         coher_reg;
    lmc_state_t   state_reg;
    lmc_state_t   state_next;

    // Merge write data into an old word under the byte enables.
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
        for (int b = 0; b < 4; b++) begin
            merge[b*8 +: 8] = sel[b] ? new_v[b*8 +: 8] : old_v[b*8 +: 8];
        end
    endfunction

    // Bus request decode; the access is served in the cycle ack rises.
    wire         bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire         bus_wr    = bus_req && wb_we_i;
    wire         hit_misc  = (wb_adr_i == OFS_MISC);
    wire         hit_ctrl  = (wb_adr_i == OFS_LINK_CTRL);
    wire         hit_freq  = (wb_adr_i == OFS_LINK_FREQ);
    wire         wr_misc   = bus_wr && hit_misc;
    wire [31:0]  misc_wval = merge(misc_reg, wb_dat_i, wb_sel_i);
    wire [31:0]  ctrl_wval = merge(ctrl_reg, wb_dat_i, wb_sel_i);
    wire [31:0]  freq_old  = {20'h0_0000, freq_reg, 8'h00};
    wire [31:0]  freq_wval = merge(freq_old, wb_dat_i, wb_sel_i);

    // Readable view of misc: reserved zero, strap and constant bits live.
    wire [31:0]  misc_view;
    assign misc_view = {1'b0, misc_reg[BIT_STOP:BIT_DWORD], coher_reg,
                        misc_reg[BIT_IGN_ORD], 1'b1, misc_reg[SEQ_HI:0]};

    // Read data mux; an unmapped address reads as zero.
    wire [31:0]  rd_data;
    assign rd_data = hit_misc ? misc_view :
                     hit_ctrl ? ctrl_reg :
                     hit_freq ? freq_old : 32'h0000_0000;

    // ------------------------------------------------------------------
    // Trigger detection
    // ------------------------------------------------------------------
    // act only on a 0-to-1 change
    wire stop_rise = wr_misc && misc_wval[BIT_STOP] && !misc_reg[BIT_STOP];
    wire wake_rise = wr_misc && misc_wval[BIT_WAKE] && !misc_reg[BIT_WAKE];

    // Next misc value keeps read-only and reserved bits at their reset.
    always_comb begin
        misc_next = misc_reg;
        if (wr_misc) begin
            misc_next = misc_wval;
        end
        misc_next[BIT_RSVD]    = MISC_RESET[BIT_RSVD];
        misc_next[BIT_COHER]   = MISC_RESET[BIT_COHER];
        misc_next[BIT_KEEP_ID] = MISC_RESET[BIT_KEEP_ID];
    end

    // ------------------------------------------------------------------
    // Wishbone slave and register storage
    // ------------------------------------------------------------------
    // Ack one cycle after the strobe and drop it the cycle after.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i) begin
                wb_dat_o <= rd_data;
            end
        end
    end

    // priority fields reset with the register
    // response and posted reset with it too
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            misc_reg <= MISC_RESET;
            ctrl_reg <= CTRL_RESET;
            freq_reg <= FREQ_RESET;
        end else begin
            misc_reg <= misc_next;
            if (bus_wr && hit_ctrl) begin
                ctrl_reg <= ctrl_wval & CTRL_RESET;
            end
            if (bus_wr && hit_freq) begin
                freq_reg <= freq_wval[FREQ_HI:FREQ_LO];
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            coher_reg <= 1'b0;
        end else begin
            coher_reg <= coherency_strap_pin;
        end
    end

    // ------------------------------------------------------------------
    // Link power state machine
    // ------------------------------------------------------------------
    // Next state from triggers and link accesses.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            LINK_UP: begin
                if (stop_rise) begin
                    state_next = LINK_DISC;
                end
            end
            LINK_DISC: begin
                if (wake_rise || link_access_req) begin
                    state_next = LINK_WAKE;
                end
            end
            LINK_WAKE: begin
                state_next = LINK_UP;
            end
            default: begin
                state_next = LINK_UP;
            end
        endcase
    end

    // State register and link pin flops.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_reg          <= LINK_UP;
            link_halt_signal_n <= 1'b1;
            link_req_n         <= 1'b1;
            phy_shutdown       <= 1'b0;
        end else begin
            state_reg          <= state_next;
            link_halt_signal_n <= (state_next != LINK_DISC);
            link_req_n         <= (state_next != LINK_WAKE);
            // PHY off only with tristate enable
            phy_shutdown       <= (state_next == LINK_DISC) &&
                                  ctrl_reg[BIT_TRI_EN];
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            active_link_freq <= FREQ_RESET;
        end else if (state_reg == LINK_WAKE) begin
            active_link_freq <= freq_reg;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt vector and command formatting
    // ------------------------------------------------------------------
    // reserved type gives no vector
    wire irq_ok = special_irq_valid && (special_irq_type != IRQ_RSVD);

    // Vector and command attribute flops.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            irq_vector_valid <= 1'b0;
            irq_vector       <= 8'h00;
            cmd_seq_id       <= 4'h0;
            wide_write_dword <= MISC_RESET[BIT_DWORD];
            ignore_ordering  <= MISC_RESET[BIT_IGN_ORD];
        end else begin
            irq_vector_valid <= irq_ok;
            // redirect field forms upper vector bits
            if (irq_ok) begin
                irq_vector <= {misc_reg[RDR_HI:RDR_LO], special_irq_type};
            end
            cmd_seq_id <= misc_reg[BIT_KEEP_ID] ? misc_reg[SEQ_HI:SEQ_LO]
                                                : axi_seq_id;
            wide_write_dword <= misc_reg[BIT_DWORD];
            ignore_ordering  <= misc_reg[BIT_IGN_ORD];
        end
    end

    // ------------------------------------------------------------------
    // Channel arbitration
    // ------------------------------------------------------------------
    // aging arbiter seeded by the priority fields
    lmc_arbiter u_arb (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .init_prio ({misc_reg[PRIO_PST_LO +: PRIO_W],
                     misc_reg[PRIO_RSP_LO +: PRIO_W],
                     misc_reg[PRIO_NPC_LO +: PRIO_W],
                     misc_reg[PRIO_NOP_LO +: PRIO_W]}),
        .ch_req    (ch_req),
        .ch_grant  (ch_grant)
    );

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    // Each assertion except a_ack_single names its clock and reset on the line below its label.
    a_stop_enter: assert property (
        @(posedge ref_clk) disable iff (reset)
        (state_reg == LINK_UP && stop_rise) |=> !link_halt_signal_n)
        else $error("stop trigger did not halt the link");

    a_wake_pulse: assert property (
        @(posedge ref_clk) disable iff (reset)
        $fell(link_req_n) |-> $past(state_reg) == LINK_DISC ##1 link_req_n)
        else $error("link request not a single wake pulse");

    a_access_wake: assert property (
        @(posedge ref_clk) disable iff (reset)
        (state_reg == LINK_DISC && link_access_req) |=> !link_req_n)
        else $error("link access did not wake the link");

    a_vector_form: assert property (
        @(posedge ref_clk) disable iff (reset)
        irq_vector_valid |-> irq_vector ==
            {$past(misc_reg[RDR_HI:RDR_LO]), $past(special_irq_type)})
        else $error("interrupt vector malformed");

    a_rsvd_type: assert property (
        @(posedge ref_clk) disable iff (reset)
        (special_irq_valid && special_irq_type == IRQ_RSVD)
            |=> !irq_vector_valid)
        else $error("reserved interrupt type produced a vector");

    a_coher_mirror: assert property (
        @(posedge ref_clk) disable iff (reset)
        misc_view[BIT_COHER] == $past(coherency_strap_pin))
        else $error("coherency bit does not follow the strap");

    a_fixed_seq: assert property (
        @(posedge ref_clk) disable iff (reset)
        ##1 cmd_seq_id == $past(misc_reg[SEQ_HI:SEQ_LO]))
        else $error("outgoing sequence ID not the fixed one");

    a_phy_gate: assert property (
        @(posedge ref_clk) disable iff (reset)
        phy_shutdown |-> !link_halt_signal_n && $past(ctrl_reg[BIT_TRI_EN]))
        else $error("PHY shut down without disconnect or enable");

    a_freq_hold: assert property (
        @(posedge ref_clk) disable iff (reset)
        (state_reg != LINK_WAKE) |=> $stable(active_link_freq))
        else $error("link frequency changed outside a wake");

    a_no_retrig: assert property (
        @(posedge ref_clk) disable iff (reset)
        (state_reg == LINK_UP && !stop_rise) |=> state_reg == LINK_UP)
        else $error("link left up without a stop edge");

    a_rsvd_zero: assert property (
        @(posedge ref_clk) disable iff (reset)
        misc_view[BIT_RSVD] == 1'b0 && misc_view[BIT_KEEP_ID] == 1'b1)
        else $error("reserved or fixed misc bit wrong");

    a_ack_single: assert property (@(posedge ref_clk) disable iff (reset)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held for more than one cycle");

    // Covers for a full stop and wake, an access wake, a vector and a PHY off.
    c_stop_wake: cover property (@(posedge ref_clk) disable iff (reset)
        state_reg == LINK_DISC ##[1:50] state_reg == LINK_WAKE);

    c_access_wake: cover property (@(posedge ref_clk) disable iff (reset)
        state_reg == LINK_DISC && link_access_req);

    c_vector_out: cover property (@(posedge ref_clk) disable iff (reset)
        irq_vector_valid);

    c_phy_off: cover property (@(posedge ref_clk) disable iff (reset)
        phy_shutdown);

endmodule

// ==== test/lmc_peer_model.sv ====
// Behavioural peer link device facing the link power pins.
`timescale 1ns/1ps
module lmc_peer_model (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset,
    // Power pins from the controller
    input  wire logic       link_halt_signal_n,
    input  wire logic       link_req_n,
    // Bench command and link side outputs
    input  wire logic       access_go,
    output logic            link_access_req,
    output logic            peer_awake,
    output logic [7:0]      wake_count
);
    // halt and wake
    // The peer sleeps while halt is low and counts every wake cycle.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            peer_awake      <= 1'b1;
            wake_count      <= 8'h00;
            link_access_req <= 1'b0;
        end else begin
            peer_awake      <= link_halt_signal_n;
            link_access_req <= access_go;  // Direct access aimed at the link.
            if (link_req_n === 1'b0) begin
                wake_count <= wake_count + 8'h01;
            end
        end
    end
endmodule

// ==== test/tb_link_controller_misc_control.sv ====
// Self-checking bench for the misc link control register bank.
`timescale 1ns/1ps
module tb_link_controller_misc_control;
    import lmc_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        ref_clk = 1'b0, reset = 1'b1, strap = 1'b0, go = 1'b0;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, irq_v = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0, axi_id = 4'h0, ch_req = 4'h0;
    logic [2:0]  irq_t = 3'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat, misc_exp, q;
    logic        ack, halt_n, req_n, phy_off, acc, vec_v, dword, ign, awake;
    logic [3:0]  freq, seq_id, grant, seen;
    logic [7:0]  vec, wakes, w0;
    logic [7:0]  vec_q[$];
    int          fail_count = 0, total_checks = 0, seed, n;

    lmc_top u_dut (.ref_clk(ref_clk), .reset(reset), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .link_halt_signal_n(halt_n), .link_req_n(req_n),
        .phy_shutdown(phy_off), .active_link_freq(freq),
        .link_access_req(acc), .coherency_strap_pin(strap),
        .special_irq_valid(irq_v), .special_irq_type(irq_t),
        .irq_vector_valid(vec_v), .irq_vector(vec), .axi_seq_id(axi_id),
        .cmd_seq_id(seq_id), .wide_write_dword(dword),
        .ignore_ordering(ign), .ch_req(ch_req), .ch_grant(grant));
    lmc_peer_model u_peer (.ref_clk(ref_clk), .reset(reset),
        .link_halt_signal_n(halt_n), .link_req_n(req_n), .access_go(go),
        .link_access_req(acc), .peer_awake(awake), .wake_count(wakes));

    // Clock and vector capture.
    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (vec_v === 1'b1) vec_q.push_back(vec);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Expected register after a byte-merged write; fixed bits forced.
    function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] d,
                                          logic [3:0] s);
        logic [31:0] r;
        for (int i = 0; i < 4; i++) r[i*8+:8] = s[i] ? d[i*8+:8] : o[i*8+:8];
        r[31] = 1'b0;
        r[22] = strap;
        r[20] = 1'b1;
        return r;
    endfunction

    // Expected vector for the i-th captured event; type 3 is skipped.
    function automatic logic [7:0] exp_vec(input int i);
        return {misc_exp[28:24], 3'(i < 3 ? i : i + 1)};
    endfunction

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One classic Wishbone cycle; waits for ack under a bound.
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d, input logic [3:0] s);
        int k;
        k = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wr;
        adr <= a;
        wdat <= d;
        sel <= s;
        do begin
            @(posedge ref_clk);
            k++;
        end while (ack !== 1'b1 && k < 50);
        if (k >= 50) fail_count++;
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic wr_misc(input logic [31:0] d, input logic [3:0] s);
        xfer(1'b1, OFS_MISC, d, s);
        misc_exp = merge(misc_exp, d, s);
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a,
                          input logic [31:0] e);
        xfer(1'b0, a, 32'h0000_0000, 4'hF);
        chk(nm, e, q);
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Watchdog against a hung handshake.
    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = $urandom(12);
        misc_exp = MISC_RESET;
        repeat (8) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rd_chk("misc reset", OFS_MISC, MISC_RESET);
        rd_chk("unmapped", 8'h10, 32'h0000_0000);
        // Random contents with both triggers held clear.
        repeat (6) begin
            strap <= 1'($urandom());
            axi_id <= 4'($urandom());
            wr_misc($urandom() & 32'h9FFF_FFFF, 4'hF);
            rd_chk("misc", OFS_MISC, misc_exp);
            chk("seq id", misc_exp[19:16], seq_id);
            chk("dword", misc_exp[23], dword);
            chk("ign ord", misc_exp[21], ign);
        end
        // Every special interrupt type back to back.
        for (int t = 0; t < 8; t++) begin
            irq_v <= 1'b1;
            irq_t <= 3'(t);
            @(posedge ref_clk);
        end
        irq_v <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk("irq count", 7, vec_q.size());
        foreach (vec_q[i])
            chk("irq vec", exp_vec(i), vec_q[i]);
        // Stop with shutdown enabled, then wake by software.
        xfer(1'b1, OFS_LINK_FREQ, 32'h0000_0500, 4'hF);
        wr_misc(misc_exp | 32'h4000_0000, 4'hF);
        chk("freq held", 4'h0, freq);
        chk("halt", 1'b0, halt_n);
        chk("phy off", 1'b1, phy_off);
        chk("peer asleep", 1'b0, awake);
        w0 = wakes;
        wr_misc(misc_exp | 32'h2000_0000, 4'hF);
        chk("halt", 1'b1, halt_n);
        chk("wakes", w0 + 8'h01, wakes);
        chk("freq", 4'h5, freq);
        chk("phy on", 1'b0, phy_off);
        chk("peer awake", 1'b1, awake);
        wr_misc(misc_exp, 4'hF);
        chk("no restop", 1'b1, halt_n);
        // Stop without shutdown, then wake by a direct access.
        xfer(1'b1, OFS_LINK_CTRL, 32'h0000_0000, 4'hF);
        wr_misc(misc_exp & 32'h9FFF_FFFF, 4'hF);
        wr_misc(misc_exp | 32'h4000_0000, 4'hF);
        chk("halt", 1'b0, halt_n);
        chk("phy kept", 1'b0, phy_off);
        w0 = wakes;
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        repeat (4) @(posedge ref_clk);
        chk("auto wake", 1'b1, halt_n);
        chk("wakes", w0 + 8'h01, wakes);
        // Priorities nop F, npc 2, rsp 9, posted 5 through a half write.
        wr_misc(32'hFFFF_F295, 4'h3);
        rd_chk("prio", OFS_MISC, misc_exp);
        ch_req <= 4'hF;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (grant === 4'h0 && n < 20);
        chk("first grant", 4'b0010, grant);
        seen = grant;
        repeat (60) begin
            @(posedge ref_clk);
            seen = seen | grant;
        end
        chk("aged grants", 4'hF, seen);
        ch_req <= 4'h0;
        repeat (3) @(posedge ref_clk);
        wrap_up();
    end
endmodule
